// >>> common/adc_cfg_host_pkg.sv
// constants and carrier types for the feature configuration host
// assumes a 250 MHz system clock; the host makes the serial clock itself
package adc_cfg_host_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCK_HALF_NS = 32;
    localparam int CNV_HIGH_NS = 100;
    // least times round up to whole cycles
    localparam int SCK_HALF_CYC =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNV_HIGH_CYC =
        (CNV_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_MIN_MHZ = 2;
    localparam int SCK_MHZ = 1000 / (2 * SCK_HALF_CYC * CLK_PERIOD_NS);

    // ==========================================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS = 8;
    localparam logic ACCESS_ENABLE = 1'b0;
    localparam logic SELECT_READ = 1'b1;
    localparam logic SELECT_WRITE = 1'b0;
    localparam logic [5:0] ACCESS_PATTERN = 6'h14;
    localparam logic [7:0] READ_FILL = 8'hFF;

    // ==========================================================
    // feature_config fields
    localparam int RESERVED_MSB = 7;
    localparam int RESERVED_LSB = 5;
    localparam int STATUS_EN_BIT = 4;
    localparam int SPAN_EN_BIT = 3;
    localparam int LOW_CURRENT_BIT = 2;
    localparam int EARLY_READ_BIT = 1;
    localparam int OV_FLAG_BIT = 0;
    localparam logic [7:0] FEATURE_CONFIG_RESET = 8'h01;
    localparam logic [2:0] RESERVED_VALUE = 3'h0;
    localparam logic OV_NO_EVENT = 1'b1;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_SHIFT = 3'b011,
        ST_HOLD = 3'b010,
        ST_GAP = 3'b110
    } state_type;

    typedef struct packed {
        logic valid;
        logic is_read;
        logic [7:0] wdata;
    } cfg_req_type;

    typedef struct packed {
        logic done;
        logic refused;
        logic rdata_valid;
        logic [7:0] rdata;
    } cfg_resp_type;

    typedef struct packed {
        logic convert_strobe;
        logic sck;
        logic serial_in_line;
    } pins_type;

    typedef struct packed {
        state_type st;
        logic [4:0] cnt;
        logic [4:0] bits;
        logic [15:0] tx;
        logic [7:0] rx;
        logic is_read;
        logic [2:0] sdo_sync;
        logic sdo_stable;
        pins_type pins;
        cfg_resp_type resp;
    } host_state_type;

endpackage

// >>> logic/adc_cfg_host.sv
// host that reads and writes the converter's feature configuration
// register with 16-bit frames on convert_strobe, sck, serial_in_line.
// assumes serial_out_line arrives asynchronously from the device pin.
//
// Notes on behaviour
// - frame is command byte then data byte
// - strobe held low through whole frame
// - first command bit must be zero
// - second bit selects read or write
// - six pattern bits must match
// - no register reads when devices chained
// - send one in bit 0, idle high
// - writes may share a conversion frame
// - serial clock meets mode minimum rate
// - host may stop status bits early
// - input held high between frames
`timescale 1ns/1ns
module adc_cfg_host (
    input wire logic clk,
    input wire logic srst,
    input wire adc_cfg_host_pkg::cfg_req_type req,
    output logic req_ready,
    input wire logic chained,
    output adc_cfg_host_pkg::cfg_resp_type resp,
    output logic convert_strobe,
    output logic sck,
    output logic serial_in_line,
    input wire logic serial_out_line
);

    // ==========================================================
    // state
    adc_cfg_host_pkg::host_state_type q;
    adc_cfg_host_pkg::host_state_type d;
    logic [7:0] data_byte;
    logic [1:0] cmd_sel;

    // counters run from zero, so each last value is its count less one; FIRST_DATA_BIT is CMD_BITS itself
    localparam logic [4:0] HALF_LAST =
        5'(adc_cfg_host_pkg::SCK_HALF_CYC - 1);
    localparam logic [4:0] GAP_LAST =
        5'(adc_cfg_host_pkg::CNV_HIGH_CYC - 1);
    localparam logic [4:0] LAST_BIT =
        5'(adc_cfg_host_pkg::FRAME_BITS - 1);
    localparam logic [4:0] FIRST_DATA_BIT =
        5'(adc_cfg_host_pkg::CMD_BITS);

    // ready straight from the state: a request is seen only in idle, and a
    // refused read costs one cycle with no frame on the pins
    assign req_ready = (q.st == adc_cfg_host_pkg::ST_IDLE);
    assign resp = q.resp;
    assign convert_strobe = q.pins.convert_strobe;
    assign sck = q.pins.sck;
    assign serial_in_line = q.pins.serial_in_line;

    // in a write, read-only bits sent as their harmless values: reserved zero,
    // bit 0 one so the input sits high when the strobe rises
    always_comb begin
        data_byte = req.wdata;
        data_byte[adc_cfg_host_pkg::RESERVED_MSB:
                  adc_cfg_host_pkg::RESERVED_LSB] =
            adc_cfg_host_pkg::RESERVED_VALUE;
        data_byte[adc_cfg_host_pkg::OV_FLAG_BIT] =
            adc_cfg_host_pkg::OV_NO_EVENT;
        if (req.is_read) begin
            data_byte = adc_cfg_host_pkg::READ_FILL;
        end
        cmd_sel = {adc_cfg_host_pkg::ACCESS_ENABLE,
                   adc_cfg_host_pkg::SELECT_WRITE};
        if (req.is_read) begin
            cmd_sel[0] = adc_cfg_host_pkg::SELECT_READ;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.resp.done = 1'b0;
        d.resp.refused = 1'b0;
        d.resp.rdata_valid = 1'b0;
        d.sdo_sync = {q.sdo_sync[1:0], serial_out_line};
        // a level counts only once the last two stages agree
        if (q.sdo_sync[1] == q.sdo_sync[2]) begin
            d.sdo_stable = q.sdo_sync[2];
        end
        case (q.st)
            adc_cfg_host_pkg::ST_IDLE: begin
                d.pins.convert_strobe = 1'b1;
                d.pins.sck = 1'b0;
                d.pins.serial_in_line = 1'b1;
                if (req.valid && req.is_read && chained) begin
                    d.resp.done = 1'b1;
                    d.resp.refused = 1'b1;
                end else if (req.valid) begin
                    d.tx = {cmd_sel, adc_cfg_host_pkg::ACCESS_PATTERN,
                            data_byte};
                    d.is_read = req.is_read;
                    d.pins.convert_strobe = 1'b0;
                    d.pins.serial_in_line = cmd_sel[1];
                    d.cnt = 5'h00;
                    d.bits = 5'h00;
                    d.st = adc_cfg_host_pkg::ST_SETUP;
                end
            end
            adc_cfg_host_pkg::ST_SETUP: begin
                d.cnt = q.cnt + 5'h01;
                if (q.cnt == HALF_LAST) begin
                    d.cnt = 5'h00;
                    d.st = adc_cfg_host_pkg::ST_SHIFT;
                end
            end
            adc_cfg_host_pkg::ST_SHIFT: begin
                d.cnt = q.cnt + 5'h01;
                if (q.cnt == HALF_LAST) begin
                    d.cnt = 5'h00;
                    if (!q.pins.sck) begin
                        // rising edge: device takes serial_in_line
                        d.pins.sck = 1'b1;
                        if (q.bits >= FIRST_DATA_BIT) begin
                            // device changed its output a half
                            // period ago, long past the sync delay
                            d.rx = {q.rx[6:0], q.sdo_stable};
                        end
                    end else begin
                        d.pins.sck = 1'b0;
                        d.tx = {q.tx[14:0], 1'b1};
                        d.pins.serial_in_line = q.tx[14];
                        // clocking stops after the data byte; appended
                        // status bits are never asked for
                        if (q.bits == LAST_BIT) begin
                            d.pins.serial_in_line = 1'b1;
                            d.st = adc_cfg_host_pkg::ST_HOLD;
                        end else begin
                            d.bits = q.bits + 5'h01;
                        end
                    end
                end
            end
            adc_cfg_host_pkg::ST_HOLD: begin
                d.cnt = q.cnt + 5'h01;
                if (q.cnt == HALF_LAST) begin
                    d.cnt = 5'h00;
                    // strobe high releases the device output
                    d.pins.convert_strobe = 1'b1;
                    d.st = adc_cfg_host_pkg::ST_GAP;
                end
            end
            adc_cfg_host_pkg::ST_GAP: begin
                d.cnt = q.cnt + 5'h01;
                // the strobe stays high for the whole gap, so the next command after a
                // finished frame follows a clean strobe-high interval; a reset skips the gap
                if (q.cnt == GAP_LAST) begin
                    d.cnt = 5'h00;
                    d.resp.done = 1'b1;
                    d.resp.rdata_valid = q.is_read;
                    if (q.is_read) begin
                        d.resp.rdata = q.rx;
                    end
                    d.st = adc_cfg_host_pkg::ST_IDLE;
                end
            end
            default: begin
                d.st = adc_cfg_host_pkg::ST_IDLE;
            end
        endcase
    end

    // reset puts every pin at its idle level at once: a frame cut short
    // ends with the strobe rising, and the device drops a partial command
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            q.st <= adc_cfg_host_pkg::ST_IDLE;
            q.pins.convert_strobe <= 1'b1;
            q.pins.serial_in_line <= 1'b1;
            q.resp.rdata <= adc_cfg_host_pkg::FEATURE_CONFIG_RESET;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // checks
    logic [4:0] rise_cnt_q;
    always_ff @(posedge clk) begin
        if (srst || q.pins.convert_strobe) begin
            rise_cnt_q <= 5'h00;
        end else if (d.pins.sck && !q.pins.sck) begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end

    // cycles since the last rise; it saturates, so a stalled clock
    // still reads as too slow instead of wrapping back into range
    localparam int SCK_MAX_CYC = 1000 /
        (adc_cfg_host_pkg::SCK_MIN_MHZ * adc_cfg_host_pkg::CLK_PERIOD_NS);
    logic [7:0] sck_per_q;
    always_ff @(posedge clk) begin
        if (srst || (d.pins.sck && !q.pins.sck)) begin
            sck_per_q <= 8'h01;
        end else if (sck_per_q != 8'hFF) begin
            sck_per_q <= sck_per_q + 8'h01;
        end
    end

    a_sixteen_rises: assert property (
        @(posedge clk) disable iff (srst)
        $rose(convert_strobe) |-> rise_cnt_q == LAST_BIT + 5'h01)
        else $error("frame did not carry sixteen clock rises");

    a_strobe_low_frame: assert property (
        @(posedge clk) disable iff (srst)
        $fell(convert_strobe) |-> !convert_strobe [*8])
        else $error("strobe rose early in frame");

    // low for setup, 32 half periods and hold: 8 + 256 + 8 cycles
    a_frame_length: assert property (
        @(posedge clk) disable iff (srst)
        $fell(convert_strobe) |-> ##271 !convert_strobe ##1 convert_strobe)
        else $error("strobe low time not one full frame");

    a_shift_strobe_low: assert property (
        @(posedge clk) disable iff (srst)
        (q.st == adc_cfg_host_pkg::ST_SHIFT) |-> !convert_strobe)
        else $error("clocking while strobe high");

    a_idle_pins: assert property (
        @(posedge clk) disable iff (srst)
        req_ready |-> convert_strobe && !sck)
        else $error("pins not idle while ready");

    a_input_on_fall: assert property (
        @(posedge clk) disable iff (srst)
        !convert_strobe && $changed(serial_in_line) && !$fell(convert_strobe)
        |-> $fell(sck))
        else $error("input changed away from a clock fall");

    a_first_bit_zero: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sck) && rise_cnt_q == 5'h01 |-> !serial_in_line)
        else $error("first command bit not zero");

    a_select_bit: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sck) && rise_cnt_q == 5'h02
        |-> serial_in_line == q.is_read)
        else $error("read or write select wrong");

    a_pattern_bits: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sck) && rise_cnt_q >= 5'h03 && rise_cnt_q <= 5'h08
        |-> serial_in_line == adc_cfg_host_pkg::ACCESS_PATTERN[
            3'(5'h08 - rise_cnt_q)])
        else $error("access pattern bit wrong");

    a_last_bit_high: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sck) && rise_cnt_q == 5'h10 |-> serial_in_line)
        else $error("bit 0 position not sent high");

    a_idle_input_high: assert property (
        @(posedge clk) disable iff (srst)
        convert_strobe |-> serial_in_line)
        else $error("input not high between frames");

    a_no_chained_read: assert property (
        @(posedge clk) disable iff (srst)
        req.valid && req.is_read && chained && req_ready
        |=> resp.refused && convert_strobe)
        else $error("read started on chained devices");

    a_read_with_done: assert property (
        @(posedge clk) disable iff (srst)
        resp.rdata_valid |-> resp.done && !resp.refused)
        else $error("read data flagged outside a done read");

    a_sck_high_time: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sck) |-> sck [*8] ##1 !sck)
        else $error("serial clock high phase wrong");

    a_sck_fast_enough: assert property (
        @(posedge clk) disable iff (srst)
        d.pins.sck && !q.pins.sck && rise_cnt_q != 5'h00
        |-> sck_per_q <= 8'(SCK_MAX_CYC))
        else $error("serial clock below minimum");

    a_gap_high: assert property (
        @(posedge clk) disable iff (srst)
        $rose(convert_strobe) |-> ##25 convert_strobe)
        else $error("strobe high gap too short");

    c_write_frame: cover property (@(posedge clk) disable iff (srst)
        resp.done && !resp.rdata_valid && !resp.refused);
    c_read_frame: cover property (@(posedge clk) disable iff (srst)
        resp.rdata_valid);
    c_refused_read: cover property (@(posedge clk) disable iff (srst)
        resp.refused);
    c_flag_read: cover property (@(posedge clk) disable iff (srst)
        resp.rdata_valid && !resp.rdata[adc_cfg_host_pkg::OV_FLAG_BIT]);

endmodule // adc_cfg_host

// >>> dv/adc_cfg_dev_model.sv
// behavioural model of the converter's configuration register port
// assumes the host frames with convert_strobe low and sck idle low
`timescale 1ns/1ns
module adc_cfg_dev_model #(
    parameter logic [5:0] PATTERN = 6'h14
) (
    input wire logic convert_strobe,
    input wire logic sck,
    input wire logic serial_in_line,
    input wire logic ov_event,
    output logic serial_out_line,
    output logic [7:0] reg_q
);
    logic [4:0] n;
    logic [15:0] sh;
    logic [7:0] out_sh;
    logic rd_ok;
    // six status bits a conversion would append when bit 4 is set
    logic [5:0] status_bits;
    assign status_bits = {reg_q[0], reg_q[3:1], 2'b00};
    initial begin
        reg_q = 8'h01;
        n = '0;
        sh = '0;
        out_sh = '0;
        rd_ok = 1'b0;
        serial_out_line = 1'b0;
    end
    // ==========================================================
    // command and data shifting
    always @(negedge convert_strobe) begin
        n = '0;
        rd_ok = 1'b0;
    end
    always @(posedge sck) if (!convert_strobe) begin
        sh = {sh[14:0], serial_in_line};
        n = n + 5'd1;
        // only bits 4..1 take the byte; reserved and flag ignore it
        if (n == 5'd16 && sh[15:8] == {2'b00, PATTERN}) begin
            reg_q[4:1] = sh[4:1];
        end
    end
    always @(negedge sck) if (!convert_strobe) begin
        if (n == 5'd8 && sh[7:0] == {2'b01, PATTERN}) begin
            rd_ok = 1'b1;
            out_sh = reg_q;
            if (!ov_event) reg_q[0] = 1'b1;
        end
        if (rd_ok) begin
            serial_out_line = out_sh[7];
            out_sh = {out_sh[6:0], 1'b0};
        end
    end
    // released line: inverse of last bit so a stale value never matches
    always @(posedge convert_strobe) begin
        rd_ok = 1'b0;
        serial_out_line = ~serial_out_line;
    end
    always @(posedge ov_event) reg_q[0] = 1'b0;
endmodule // adc_cfg_dev_model

// >>> dv/adc_cfg_host_tb.sv
// self-checking bench for the configuration register host
// assumes a device model on the pins and a second one with a bad pattern
`timescale 1ns/1ns
module adc_cfg_host_tb;
    logic clk;
    logic srst;
    logic chained;
    logic ov_event;
    logic req_ready;
    logic convert_strobe;
    logic sck;
    logic serial_in_line;
    logic serial_out_line;
    logic [7:0] dev_reg;
    logic [7:0] bad_reg;
    adc_cfg_host_pkg::cfg_req_type req;
    adc_cfg_host_pkg::cfg_resp_type resp;
    adc_cfg_host_pkg::cfg_resp_type resp_q;
    int fail_count = 0;
    int num_checks = 0;
    int rises = 0;
    int frames = 0;
    int f0;
    // rows: is_read, write byte, expected read byte or register
    logic [16:0] rows[6] = '{{1'b1, 8'h00, 8'h01}, {1'b0, 8'hFF, 8'h1F},
        {1'b1, 8'h00, 8'h1F}, {1'b0, 8'hA5, 8'h05},
        {1'b1, 8'h00, 8'h05}, {1'b0, 8'h12, 8'h13}};
    adc_cfg_host i_dut (.clk(clk), .srst(srst), .req(req),
        .req_ready(req_ready), .chained(chained), .resp(resp),
        .convert_strobe(convert_strobe), .sck(sck),
        .serial_in_line(serial_in_line), .serial_out_line(serial_out_line));
    adc_cfg_dev_model i_dev (.convert_strobe(convert_strobe), .sck(sck),
        .serial_in_line(serial_in_line), .ov_event(ov_event),
        .serial_out_line(serial_out_line), .reg_q(dev_reg));
    adc_cfg_dev_model #(.PATTERN(6'h2B)) i_bad (
        .convert_strobe(convert_strobe), .sck(sck),
        .serial_in_line(serial_in_line), .ov_event(1'b0),
        .serial_out_line(), .reg_q(bad_reg));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_req(input logic rd, input logic [7:0] wd);
        int k;
        req = '{1'b1, rd, wd};
        while (req_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        req.valid = 1'b0;
        for (k = 0; k < 400 && resp.done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        resp_q = resp;
        check16({15'h0, resp.done}, 16'h0001);
        @(posedge clk);
        #1;
        check16({15'h0, resp.done}, 16'h0000);
    endtask
    // ==========================================================
    // wire monitor: framing and idle level
    always @(negedge convert_strobe) rises = 0;
    always @(posedge sck) begin
        rises++;
        check16({15'h0, convert_strobe}, 16'h0000);
    end
    always @(posedge convert_strobe) if (srst === 1'b0) begin
        frames++;
        check16(16'(rises), 16'h0010);
        check16({15'h0, serial_in_line}, 16'h0001);
    end
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        srst = 1'b1;
        chained = 1'b0;
        ov_event = 1'b0;
        req = '0;
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk);
        #1;
        check16({13'h0, convert_strobe, sck, serial_in_line}, 16'h0005);
        check16({8'h0, resp.rdata}, 16'h0001);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            do_req(rows[i][16], rows[i][15:8]);
            check16({15'h0, resp_q.rdata_valid}, {15'h0, rows[i][16]});
            if (rows[i][16]) check16({8'h0, resp_q.rdata}, {8'h0, rows[i][7:0]});
            else check16({8'h0, dev_reg}, {8'h0, rows[i][7:0]});
        end
        check16({8'h0, bad_reg}, 16'h0001);
        check16({10'h0, i_dev.status_bits}, 16'h0024);
        $display("row test done");
        // flag sticks while the event lasts, clears on a later read
        ov_event = 1'b1;
        do_req(1'b1, 8'h00);
        check16({8'h0, resp_q.rdata}, 16'h0012);
        ov_event = 1'b0;
        do_req(1'b1, 8'h00);
        check16({8'h0, resp_q.rdata}, 16'h0012);
        do_req(1'b1, 8'h00);
        check16({8'h0, resp_q.rdata}, 16'h0013);
        $display("overvoltage test done");
        f0 = frames;
        chained = 1'b1;
        do_req(1'b1, 8'h00);
        check16({15'h0, resp_q.refused}, 16'h0001);
        do_req(1'b0, 8'h08);
        chained = 1'b0;
        check16(16'(frames - f0), 16'h0001);
        check16({8'h0, dev_reg}, 16'h0009);
        $display("chained test done");
        // reset cut into a write: pins idle at once, device keeps old value
        req = '{1'b1, 1'b0, 8'h1E};
        @(posedge clk);
        #1;
        req.valid = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        check16({13'h0, convert_strobe, sck, serial_in_line}, 16'h5);
        check16({7'h0, req_ready, resp.rdata}, 16'h0101);
        do_req(1'b1, 8'h00);
        check16({8'h0, resp_q.rdata}, 16'h0009);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule // adc_cfg_host_tb
